// ==== rswd_top.sv ====
// reset supervisor and watchdog with avalon register slave
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Function
// - any of four sources asserts internal reset
// - internal reset plus active-low copy outward
// - low-voltage reset held 10ms after recovery
// - low-voltage reset on by default, software-disable
// - low-voltage logic works in idle, power-down
// - 1us filter ignores short supply dips
// - watchdog overflow asserts internal reset
// - 4 se0 samples set usb flag
// - enable bit 6 makes usb reset internal
// - watchdog keeps counting during idle
// - watchdog enabled after power-up and reset
// - count per machine cycle, 22-bit overflow
// - reload value goes to top seven bits
// - reload of zero clears whole counter
// - only key 55h disables the watchdog
// - watchdog pulse lasts 12 times 2^15
// - bit 5 of power control disables
// - only pin and low-voltage resets act in power-down
module rswd_top
	import rswd_pkg::*;
#(
	parameter int unsigned LVR_HOLD_CYCLES = rswd_pkg::LVR_HOLD_CYCLES_DEF, // lvr hold
	parameter int unsigned WD_PULSE_CYCLES = rswd_pkg::WD_PULSE_CYCLES_DEF, // wd pulse
	parameter int unsigned MC_CYCLES       = rswd_pkg::MC_OSC_PERIODS       // clocks per machine cycle
)(
	input  wire logic                        clk_sys,          // oscillator clock
	input  wire logic                        resetn,           // power-on reset, active low
	input  wire logic                        reset_pin_n,      // external reset pin, low active
	input  wire logic                        lvd_below,        // supply below threshold
	input  wire logic                        usb_se0,          // single-ended zero upstream
	input  wire logic                        power_down_mode,  // core in power-down
	input  wire logic [rswd_pkg::ADDR_W-1:0] avs_address,      // byte address
	input  wire logic                        avs_read,         // read request
	input  wire logic                        avs_write,        // write request
	input  wire logic [rswd_pkg::DATA_W-1:0] avs_writedata,    // write data
	input  wire logic [3:0]                  avs_byteenable,   // byte lanes
	output logic      [rswd_pkg::DATA_W-1:0] avs_readdata,     // read data
	output logic                             avs_waitrequest,  // slave stall
	output logic                             core_reset,       // internal reset, high
	output logic                             psd_reset_n       // copy for system module
);

	// whole block state in one record
	typedef struct packed {
		logic                    ack;      // second cycle of an access
		logic [DATA_W-1:0]       rdata;    // read data held for completion
		logic                    lvr_dis;  // low_voltage_reset_disable
		logic [7:0]              key;      // watchdog_key
		logic                    usb_flag; // usb_bus_reset_flag
		logic                    usb_en;   // usb_bus_reset_enable
		logic [PRESCALE_W-1:0]   prescale; // machine cycle divider
		logic [WD_WIDTH-1:0]     wd_count; // watchdog_counter
		logic [WD_PULSE_W-1:0]   wd_pulse; // watchdog reset pulse remaining
		logic [LVR_FILTER_W-1:0] lvr_filt; // consecutive low-supply cycles
		logic                    lvr_low;  // filtered low-supply level
		logic [LVR_HOLD_W-1:0]   lvr_hold; // hold after recovery
		logic [USB_RUN_W-1:0]    se0_run;  // consecutive se0 samples
		logic                    int_reset; // registered internal reset
	} rswd_state_t;

	localparam rswd_state_t ST_RESET = '{int_reset: 1'b1, default: '0}; // power-on state

	localparam logic [PRESCALE_W-1:0]   MC_LAST   = PRESCALE_W'(MC_CYCLES - 1);
	localparam logic [LVR_FILTER_W-1:0] FILT_LAST = LVR_FILTER_W'(LVR_FILTER_CYCLES - 1);
	localparam logic [LVR_HOLD_W-1:0]   HOLD_LOAD = LVR_HOLD_W'(LVR_HOLD_CYCLES);
	localparam logic [WD_PULSE_W-1:0]   PULSE_LOAD = WD_PULSE_W'(WD_PULSE_CYCLES);
	localparam logic [USB_RUN_W-1:0]    SE0_DONE  = USB_RUN_W'(USB_SE0_SAMPLES);
	localparam logic [WD_LOW_W-1:0]     WD_LOW_ZERO = '0;

	rswd_state_t       state;       // registered state
	rswd_state_t       next_state;  // next state
	logic [SYNC_W-1:0] sync_lines;  // synchronised sources
	logic              pin_low_s;   // external pin asserted
	logic              lvd_s;       // supply low, synchronised
	logic              se0_s;       // se0, synchronised
	logic              osc_run;     // oscillator not stopped
	logic              mc_tick;     // last clock of a machine cycle
	logic              wd_enabled;  // key does not disable
	logic              wd_overflow; // counter wraps this cycle
	logic              src_ext;     // pin source
	logic              src_lvr;     // low-voltage source
	logic              src_usb;     // usb bus reset source
	logic              src_wd;      // watchdog source
	logic              usb_detect;  // se0 run complete
	logic              complete;    // access completes this edge
	logic              wr;          // write takes effect
	logic [7:0]        wdata8;      // low write byte
	logic [DATA_W-1:0] rd_mux;      // read value of addressed register

	// index match on the word part of the byte address
	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [IDX_W-1:0] idx);
		reg_hit = (addr[ADDR_W-1:2] == idx);
	endfunction : reg_hit

	// pin, supply and usb lines cross into clk_sys here
	rswd_sync u_sync (
		.clk_sys  (clk_sys),
		.resetn   (resetn),
		.async_in ({usb_se0, lvd_below, ~reset_pin_n}),
		.sync_out (sync_lines)
	);

	assign pin_low_s = sync_lines[0];
	assign lvd_s     = sync_lines[1];
	assign se0_s     = sync_lines[2];

	// oscillator stops in power-down, so counting stops too; idle leaves it running
	assign osc_run     = !power_down_mode;
	assign mc_tick     = osc_run && (state.prescale == MC_LAST);
	assign wd_enabled  = (state.key != WD_DISABLE_KEY);
	assign wd_overflow = wd_enabled && mc_tick && (&state.wd_count);

	// reset sources; power-down masks the ones that need the oscillator
	assign src_ext    = pin_low_s;
	assign src_lvr    = !state.lvr_dis && (state.lvr_low || (state.lvr_hold != '0));
	assign usb_detect = (state.se0_run == SE0_DONE);
	assign src_usb    = usb_detect && state.usb_en && osc_run;
	assign src_wd     = (state.wd_pulse != '0) && osc_run;

	// bus handshake: one wait state, effect at the completing edge
	assign complete        = (avs_read || avs_write) && state.ack;
	assign avs_waitrequest = (avs_read || avs_write) && !state.ack;
	assign wr              = avs_write && complete && avs_byteenable[0];
	assign wdata8          = avs_writedata[7:0];

	// read mux; unmapped and write-only locations read zero
	always_comb begin
		rd_mux = '0;
		if (reg_hit(avs_address, IDX_KEY)) begin
			rd_mux[7:0] = state.key;
		end else if (reg_hit(avs_address, IDX_POWER_CONTROL_REGISTER)) begin
			rd_mux[POWER_CONTROL_REGISTER_LVR_DIS_BIT] = state.lvr_dis;
		end else if (reg_hit(avs_address, IDX_USB_STAT)) begin
			rd_mux[USB_STAT_RST_BIT] = state.usb_flag;
		end else if (reg_hit(avs_address, IDX_USB_EN)) begin
			rd_mux[USB_EN_RST_BIT] = state.usb_en;
		end
	end

	// next state of the whole block
	always_comb begin
		next_state     = state;
		next_state.ack = (avs_read || avs_write) && !state.ack;

		// read data captured on the stall cycle, stands at completion
		if (avs_read && !state.ack) begin
			next_state.rdata = rd_mux;
		end

		// machine cycle divider, free in idle
		if (osc_run) begin
			next_state.prescale = (state.prescale == MC_LAST) ? '0 : state.prescale + 1'b1;
		end

		// control registers return to defaults on any internal reset
		if (state.int_reset) begin
			next_state.key     = WD_KEY_RST;
			next_state.lvr_dis = 1'b0;
			next_state.usb_en  = 1'b0;
		end else if (wr) begin
			if (reg_hit(avs_address, IDX_KEY)) begin
				next_state.key = wdata8;
			end
			if (reg_hit(avs_address, IDX_POWER_CONTROL_REGISTER)) begin
				next_state.lvr_dis = wdata8[POWER_CONTROL_REGISTER_LVR_DIS_BIT];
			end
			if (reg_hit(avs_address, IDX_USB_EN)) begin
				next_state.usb_en = wdata8[USB_EN_RST_BIT];
			end
		end

		// watchdog counter: reset clears, reload loads top bits, else count
		if (state.int_reset) begin
			next_state.wd_count = '0;
		end else if (wr && reg_hit(avs_address, IDX_RELOAD)) begin
			next_state.wd_count = {wdata8[WD_LOAD_W-1:0], WD_LOW_ZERO};
		end else if (mc_tick && wd_enabled) begin
			next_state.wd_count = state.wd_count + 1'b1;
		end

		// reset pulse stretcher, not cleared by the reset it makes
		if (wd_overflow) begin
			next_state.wd_pulse = PULSE_LOAD;
		end else if (state.wd_pulse != '0 && osc_run) begin
			next_state.wd_pulse = state.wd_pulse - 1'b1;
		end

		// supply filter runs on every clock whatever the mode
		if (lvd_s) begin
			if (state.lvr_filt == FILT_LAST) begin
				next_state.lvr_low = 1'b1;
			end else begin
				next_state.lvr_filt = state.lvr_filt + 1'b1;
			end
		end else begin
			next_state.lvr_filt = '0;
			next_state.lvr_low  = 1'b0;
		end

		// hold counter reloads while low, drains after recovery
		if (state.lvr_low) begin
			next_state.lvr_hold = HOLD_LOAD;
		end else if (state.lvr_hold != '0) begin
			next_state.lvr_hold = state.lvr_hold - 1'b1;
		end

		// se0 sampled once per machine cycle, run saturates
		if (mc_tick) begin
			if (!se0_s) begin
				next_state.se0_run = '0;
			end else if (!usb_detect) begin
				next_state.se0_run = state.se0_run + 1'b1;
			end
		end

		// flag: write-one clears, a detection in the same cycle wins
		if (wr && reg_hit(avs_address, IDX_USB_STAT) && wdata8[USB_STAT_RST_BIT]) begin
			next_state.usb_flag = 1'b0;
		end
		if (mc_tick && se0_s && (state.se0_run == SE0_DONE - 1'b1)) begin
			next_state.usb_flag = 1'b1;
		end

		// combined reset, registered so release is synchronous
		next_state.int_reset = src_ext || src_lvr || src_usb || src_wd;
	end

	// single state register
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state <= ST_RESET;
		end else begin
			state <= next_state;
		end
	end

	assign avs_readdata = state.rdata;
	assign core_reset   = state.int_reset;
	assign psd_reset_n  = !state.int_reset;

	// any source gives internal reset on the next edge
	property p_any_source;
		@(posedge clk_sys) disable iff (!resetn)
		(src_ext || src_lvr || src_usb || src_wd) |=> core_reset;
	endproperty
	a_any_source: assert property (p_any_source) else $error("source did not reset");

	// outward copy is low, and the control registers return to defaults
	property p_psd_copy;
		@(posedge clk_sys) disable iff (!resetn)
		core_reset |-> !psd_reset_n ##1 ((state.key == WD_KEY_RST) && !state.lvr_dis
			&& !state.usb_en && (state.wd_count == '0));
	endproperty
	a_psd_copy: assert property (p_psd_copy) else $error("system module reset wrong");

	// after recovery the hold drains one per cycle and keeps the source on
	property p_lvr_hold;
		@(posedge clk_sys) disable iff (!resetn)
		(!state.lvr_low && state.lvr_hold > 1 && !state.lvr_dis)
			|-> src_lvr ##1 (state.lvr_hold == $past(state.lvr_hold) - 1'b1) && src_lvr;
	endproperty
	a_lvr_hold: assert property (p_lvr_hold) else $error("lvr hold not kept");

	// disable bit only rises from a write to bit 5
	property p_lvr_dis_write;
		@(posedge clk_sys) disable iff (!resetn)
		$rose(state.lvr_dis) |-> $past(wr) && $past(wdata8[POWER_CONTROL_REGISTER_LVR_DIS_BIT]);
	endproperty
	a_lvr_dis_write: assert property (p_lvr_dis_write) else $error("lvr disabled unasked");

	// filtered level needs the full run of low samples
	sequence s_dip_long;
		lvd_s [*8];
	endsequence
	property p_lvr_filter;
		@(posedge clk_sys) disable iff (!resetn)
		$rose(state.lvr_low) |-> $past(state.lvr_filt) == FILT_LAST;
	endproperty
	a_lvr_filter: assert property (p_lvr_filter) else $error("short dip passed filter");
	property p_lvr_filter_run;
		@(posedge clk_sys) disable iff (!resetn)
		(!state.lvr_low ##1 state.lvr_low) |-> $past(lvd_s, 2);
	endproperty
	a_lvr_filter_run: assert property (p_lvr_filter_run) else $error("filter not consecutive");

	// overflow loads the pulse and resets the core
	sequence s_overflow;
		wd_overflow && !power_down_mode;
	endsequence
	sequence s_pulse_start;
		(state.wd_pulse == PULSE_LOAD) ##1 core_reset;
	endsequence
	property p_wd_overflow;
		@(posedge clk_sys) disable iff (!resetn)
		s_overflow |=> s_pulse_start;
	endproperty
	a_wd_overflow: assert property (p_wd_overflow) else $error("overflow without reset");

	// usb detection sets the flag on the completing sample
	property p_usb_flag;
		@(posedge clk_sys) disable iff (!resetn)
		(mc_tick && se0_s && state.se0_run == SE0_DONE - 1'b1) |=> state.usb_flag && usb_detect;
	endproperty
	a_usb_flag: assert property (p_usb_flag) else $error("usb flag not set");

	// enabled usb reset reaches the core
	property p_usb_reset;
		@(posedge clk_sys) disable iff (!resetn)
		(usb_detect && state.usb_en && !power_down_mode) |=> core_reset;
	endproperty
	a_usb_reset: assert property (p_usb_reset) else $error("usb reset not passed");

	// reload write puts the value in the top bits and zeroes the rest
	property p_reload;
		@(posedge clk_sys) disable iff (!resetn)
		(wr && reg_hit(avs_address, IDX_RELOAD) && !state.int_reset)
			|=> state.wd_count == {$past(wdata8[WD_LOAD_W-1:0]), WD_LOW_ZERO};
	endproperty
	a_reload: assert property (p_reload) else $error("reload value wrong");

	// disabling key freezes the counter
	property p_key_hold;
		@(posedge clk_sys) disable iff (!resetn)
		(state.key == WD_DISABLE_KEY && !state.int_reset && !wr) |=> $stable(state.wd_count);
	endproperty
	a_key_hold: assert property (p_key_hold) else $error("disabled watchdog moved");

	// power-down leaves only pin and supply as sources
	property p_power_down;
		@(posedge clk_sys) disable iff (!resetn)
		power_down_mode |-> !src_wd && !src_usb && !wd_overflow;
	endproperty
	a_power_down: assert property (p_power_down) else $error("reset in power-down");

endmodule : rswd_top

`default_nettype wire

// ==== rswd_pkg.sv ====
// constants shared by the reset supervisor and watchdog files
package rswd_pkg;

	// clock and machine cycle
	localparam int unsigned CLK_PERIOD_NS    = 100;                // clk_sys at 10 MHz
	localparam int unsigned MC_OSC_PERIODS   = 12;                 // oscillator periods per machine cycle
	localparam int unsigned PRESCALE_W       = 4;                  // machine cycle prescaler width

	// low-voltage reset timing
	localparam int unsigned LVR_HOLD_MS      = 10;                 // hold after supply recovers
	localparam int unsigned LVR_HOLD_NS      = LVR_HOLD_MS * 1000000;
	localparam int unsigned LVR_HOLD_CYCLES_DEF =
		(LVR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;         // least time, rounded up
	localparam int unsigned LVR_HOLD_W       = 17;                 // hold counter width
	localparam int unsigned LVR_FILTER_NS    = 1000;               // noise-cancelling delay
	localparam int unsigned LVR_FILTER_CYCLES =
		(LVR_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;       // rounded up
	localparam int unsigned LVR_FILTER_W     = 4;                  // filter counter width

	// external pin power-up hold, kept by the board
	localparam int unsigned PIN_HOLD_MS      = 1;                  // minimum low time at power-up

	// watchdog
	localparam int unsigned WD_WIDTH         = 22;                 // counter width
	localparam int unsigned WD_LOAD_W        = 7;                  // reload field width
	localparam int unsigned WD_LOW_W         = WD_WIDTH - WD_LOAD_W; // cleared low part
	localparam int unsigned WD_PULSE_CYCLES_DEF = MC_OSC_PERIODS * (2 ** 15); // reset pulse
	localparam int unsigned WD_PULSE_W       = 19;                 // pulse counter width
	localparam logic [7:0]  WD_DISABLE_KEY   = 8'h55;              // only key that stops it
	localparam logic [7:0]  WD_KEY_RST       = 8'h00;              // key after reset

	// usb bus reset detection
	localparam int unsigned USB_SE0_SAMPLES  = 4;                  // consecutive se0 samples
	localparam int unsigned USB_RUN_W        = 3;                  // run counter width

	// avalon slave geometry
	localparam int unsigned ADDR_W           = 10;                 // byte address width
	localparam int unsigned DATA_W           = 32;                 // data width
	localparam int unsigned IDX_W            = 8;                  // register index width

	// register indices, byte address is four times the index
	localparam logic [7:0]  IDX_RELOAD       = 8'hA6;              // watchdog_reload
	localparam logic [7:0]  IDX_KEY          = 8'hAE;              // watchdog_key
	localparam logic [7:0]  IDX_POWER_CONTROL_REGISTER         = 8'h87;              // power_control_register
	localparam logic [7:0]  IDX_USB_STAT     = 8'hF0;              // usb_interrupt_status_register
	localparam logic [7:0]  IDX_USB_EN       = 8'hF1;              // usb_interrupt_enable_register

	// field positions
	localparam int unsigned POWER_CONTROL_REGISTER_LVR_DIS_BIT = 5;                  // low_voltage_reset_disable
	localparam int unsigned USB_STAT_RST_BIT = 0;                  // usb_bus_reset_flag
	localparam int unsigned USB_EN_RST_BIT   = 6;                  // usb_bus_reset_enable

	// synchroniser inputs
	localparam int unsigned SYNC_W           = 3;                  // synchronised lines
	localparam logic [2:0]  SYNC_RST         = 3'h1;               // pin path reads asserted

endpackage : rswd_pkg

// ==== rswd_sync.sv ====
// two flip-flop synchroniser for the asynchronous reset sources
`timescale 1ns/1ps
`default_nettype none

module rswd_sync
	import rswd_pkg::*;
(
	input  wire logic                        clk_sys,   // oscillator clock
	input  wire logic                        resetn,    // async reset, active low
	input  wire logic [rswd_pkg::SYNC_W-1:0] async_in,  // raw asynchronous lines
	output logic      [rswd_pkg::SYNC_W-1:0] sync_out   // lines after two flops
);

	// both stages in one record
	typedef struct packed {
		logic [SYNC_W-1:0] meta;   // first stage, read only by stage two
		logic [SYNC_W-1:0] stable; // second stage
	} rswd_sync_t;

	rswd_sync_t state;      // registered stages
	rswd_sync_t next_state; // next stages

	// shift by one stage per edge
	always_comb begin
		next_state        = state;
		next_state.meta   = async_in;
		next_state.stable = state.meta;
	end

	// reset value keeps the pin path asserted until the first real samples
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state <= '{meta: SYNC_RST, stable: SYNC_RST};
		end else begin
			state <= next_state;
		end
	end

	assign sync_out = state.stable;

endmodule : rswd_sync

`default_nettype wire

// ==== rswd_core_model.sv ====
// behavioural model of the core side that receives the internal reset
`timescale 1ns/1ps
`default_nettype none

module rswd_core_model (
	input  wire logic        clk_sys,      // oscillator clock
	input  wire logic        core_reset,   // internal reset, high
	input  wire logic        psd_reset_n,  // system module copy, low active
	output logic      [31:0] pulse_cnt,    // reset pulses seen
	output logic      [31:0] pulse_len,    // length of last pulse in cycles
	output logic      [31:0] copy_err      // cycles where the copy disagreed
);
	logic prev = 1'b0; // core_reset one edge ago

	initial begin
		pulse_cnt = 32'h0;
		pulse_len = 32'h0;
		copy_err  = 32'h0;
	end

	// registers reload while reset is high, so count pulses and their width
	always @(posedge clk_sys) begin
		if (core_reset === 1'b1) begin
			if (prev !== 1'b1) begin
				pulse_cnt <= pulse_cnt + 32'h1;
				pulse_len <= 32'h1;
			end else begin
				pulse_len <= pulse_len + 32'h1;
			end
		end
		// the system module must see the exact inverse
		if (psd_reset_n !== ~core_reset) begin
			copy_err <= copy_err + 32'h1;
		end
		prev <= core_reset;
	end
endmodule : rswd_core_model
`default_nettype wire

// ==== tb_reset_supervisor_watchdog.sv ====
// self-checking bench for the reset supervisor and watchdog
`timescale 1ns/1ps
`default_nettype none

module tb_reset_supervisor_watchdog;
	import rswd_pkg::*;
	localparam int unsigned HOLD   = 20;                     // shortened supply hold
	localparam int unsigned PULSE  = 30;                     // shortened watchdog pulse
	localparam int unsigned MC     = 1;                      // shortened machine cycle
	localparam int unsigned WD_CYC = ((1 << WD_WIDTH) - (32'h7E << WD_LOW_W)) * MC; // 0x7E reload
	logic        clk_sys = 1'b0;        // 10 MHz clock
	logic        resetn = 1'b0;         // power-on reset
	logic        reset_pin_n = 1'b0;    // board holds pin low at power-up
	logic        lvd_below = 1'b0;      // supply comparator
	logic        usb_se0 = 1'b0;        // se0 line
	logic        power_down_mode = 1'b0; // core mode
	logic [9:0]  avs_address = 10'h000; // bus address
	logic        avs_read = 1'b0;       // bus read
	logic        avs_write = 1'b0;      // bus write
	logic [31:0] avs_writedata = 32'h0; // bus write data
	logic [31:0] avs_readdata;          // bus read data
	logic        avs_waitrequest;       // bus stall
	logic        core_reset;            // internal reset
	logic        psd_reset_n;           // copy for system module
	logic [31:0] pulse_cnt;             // pulses seen by core model
	logic [31:0] pulse_len;             // last pulse width
	logic [31:0] copy_err;              // copy mismatches
	int          failures = 0;          // mismatches
	int          n_checks = 0;          // comparisons

	rswd_top #(.LVR_HOLD_CYCLES(HOLD), .WD_PULSE_CYCLES(PULSE), .MC_CYCLES(MC)) i_rswd_top (
		.clk_sys(clk_sys), .resetn(resetn), .reset_pin_n(reset_pin_n),
		.lvd_below(lvd_below), .usb_se0(usb_se0), .power_down_mode(power_down_mode),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .core_reset(core_reset),
		.psd_reset_n(psd_reset_n));
	rswd_core_model i_rswd_core_model (.clk_sys(clk_sys), .core_reset(core_reset),
		.psd_reset_n(psd_reset_n), .pulse_cnt(pulse_cnt), .pulse_len(pulse_len),
		.copy_err(copy_err));

	// clock
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run();
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run

	// one avalon access; request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
		output logic [7:0] rd);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_address   <= {idx, 2'b00};
		avs_write     <= wr;
		avs_read      <= ~wr;
		avs_writedata <= {24'h0, wd};
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		if (n >= 50) check(32'h1, 32'h0);
	endtask : bus

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] x;
		bus(1'b1, idx, d, x);
	endtask : wr

	task automatic rd(input logic [7:0] idx, input logic [7:0] e);
		logic [7:0] x;
		bus(1'b0, idx, 8'h00, x);
		check(32'(x), 32'(e));
	endtask : rd

	// wait for core_reset to reach a level within a bound
	task automatic wait_rst(input logic lvl, input int lim);
		int n;
		n = 0;
		while (core_reset !== lvl && n < lim) begin
			@(posedge clk_sys);
			n++;
		end
		check(32'(core_reset), 32'(lvl));
	endtask : wait_rst

	// hold a level input for a number of cycles
	task automatic pulse_in(input int which, input int cyc);
		@(posedge clk_sys);
		if (which == 0) lvd_below <= 1'b1;
		else usb_se0 <= 1'b1;
		repeat (cyc) @(posedge clk_sys);
		lvd_below <= 1'b0;
		usb_se0   <= 1'b0;
	endtask : pulse_in

	task automatic t_defaults();
		rd(IDX_KEY, WD_KEY_RST);
		rd(IDX_POWER_CONTROL_REGISTER, 8'h00);
		rd(IDX_USB_EN, 8'h00);
		rd(IDX_RELOAD, 8'h00);
		rd(8'h10, 8'h00);
		wr(IDX_KEY, 8'hA5);
		rd(IDX_KEY, 8'hA5);
		$display("t_defaults done");
	endtask : t_defaults

	task automatic t_pin();
		wr(IDX_KEY, 8'h3C);
		reset_pin_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		check(32'(core_reset), 32'h1);
		check(32'(psd_reset_n), 32'h0);
		reset_pin_n <= 1'b1;
		wait_rst(1'b0, 10);
		rd(IDX_KEY, WD_KEY_RST);
		$display("t_pin done");
	endtask : t_pin

	task automatic t_lvr();
		int c;
		int n;
		c = pulse_cnt;
		pulse_in(0, 5);
		repeat (30) @(posedge clk_sys);
		check(pulse_cnt, 32'(c));
		pulse_in(0, 30);
		wait_rst(1'b1, 10);
		n = 0;
		while (core_reset === 1'b1 && n < 100) begin
			@(posedge clk_sys);
			n++;
		end
		check(32'(n >= HOLD && n <= HOLD + 7), 32'h1);
		wr(IDX_POWER_CONTROL_REGISTER, 8'h20);
		rd(IDX_POWER_CONTROL_REGISTER, 8'h20);
		c = pulse_cnt;
		pulse_in(0, 30);
		repeat (40) @(posedge clk_sys);
		check(pulse_cnt, 32'(c));
		wr(IDX_POWER_CONTROL_REGISTER, 8'h00);
		power_down_mode <= 1'b1;
		pulse_in(0, 30);
		wait_rst(1'b1, 10);
		power_down_mode <= 1'b0;
		wait_rst(1'b0, 100);
		$display("t_lvr done");
	endtask : t_lvr

	task automatic t_usb();
		int c;
		c = pulse_cnt;
		pulse_in(1, 3);
		repeat (30) @(posedge clk_sys);
		rd(IDX_USB_STAT, 8'h00);
		pulse_in(1, 8);
		repeat (30) @(posedge clk_sys);
		rd(IDX_USB_STAT, 8'h01);
		check(pulse_cnt, 32'(c));
		wr(IDX_USB_STAT, 8'h01);
		rd(IDX_USB_STAT, 8'h00);
		wr(IDX_USB_EN, 8'h40);
		rd(IDX_USB_EN, 8'h40);
		pulse_in(1, 8);
		repeat (4) @(posedge clk_sys);
		check(pulse_cnt, 32'(c + 1));
		wait_rst(1'b0, 50);
		rd(IDX_USB_EN, 8'h00);
		$display("t_usb done");
	endtask : t_usb

	task automatic t_wdog();
		int c;
		wr(IDX_RELOAD, 8'h7E);
		wr(IDX_KEY, WD_DISABLE_KEY);
		repeat (2000) @(posedge clk_sys);
		wr(IDX_KEY, 8'h3C);
		c = pulse_cnt;
		repeat (WD_CYC - 100) @(posedge clk_sys);
		check(pulse_cnt, 32'(c));
		wait_rst(1'b1, 400);
		wait_rst(1'b0, PULSE + 10);
		check(pulse_len, 32'(PULSE));
		rd(IDX_KEY, WD_KEY_RST);
		$display("t_wdog done");
	endtask : t_wdog

	// main sequence
	initial begin
		repeat (20) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (10000) @(posedge clk_sys);
		reset_pin_n <= 1'b1;
		wait_rst(1'b0, 20);
		t_defaults();
		t_pin();
		t_lvr();
		t_usb();
		t_wdog();
		check(copy_err, 32'h0);
		complete_run();
	end

	// hang guard, past the roughly 80k cycles the scenarios need
	initial begin
		#9000000;
		failures++;
		complete_run();
	end
endmodule : tb_reset_supervisor_watchdog
`default_nettype wire
